// ---- hw/ccrpu_pkg.sv ----
// Package of constants for the core clock, reset and power unit
package ccrpu_pkg;
   // ==========================================
   // Timing structure
   localparam int unsigned PHASES_PER_STATE = 2;
   localparam int unsigned STATES_PER_PCYC  = 6;
   localparam logic [2:0]  STATE_FIRST      = 3'h1;
   localparam logic [2:0]  STATE_LAST       = 3'h6;
   localparam logic [2:0]  STROBE_STATE     = 3'h5;
   localparam logic        PHASE_ONE        = 1'h0;
   localparam logic        PHASE_TWO        = 1'h1;
   // ==========================================
   // Reset and watchdog
   localparam logic [23:0] START_ADDR       = 24'hFF0000;
   localparam int unsigned WDT_WIDTH        = 14;
   localparam logic [13:0] WDT_MAX          = 14'h3FFF;
   localparam logic [13:0] WDT_ZERO         = 14'h0000;
   localparam logic [1:0]  RST_HOLD_CYCLES  = 2'h3;
   // ==========================================
   // Power modes
   typedef enum logic [1:0] {
      CCRPU_RUN  = 2'b00,
      CCRPU_IDLE = 2'b01,
      CCRPU_PDWN = 2'b10
   } ccrpu_mode_e;
endpackage : ccrpu_pkg

// ---- hw/ccrpu_core_clock_reset_power_unit.sv ----
// Clock, reset and power-saving control for the microcontroller core
// Function
// R1 - A state is two oscillator periods: phase one then phase two.
// R2 - Six states form a repeating peripheral cycle, numbered by state and phase.
// R3 - Strobe in phase two of state five advances the counter-array timer once.
// R4 - Idle mode gates the CPU clock while peripherals keep their clock.
// R5 - Powerdown halts the oscillator so all clocked logic freezes; here counters and watchdog freeze, mode and reset logic still run.
// R6 - Enabled interrupt or hardware reset ends idle or powerdown.
// R7 - Chip reset starts from the reset pin or a watchdog reaching maximum.
// R8 - Chip reset disables the watchdog until software enables it again.
// R9 - After any reset the first fetch comes from the fixed start address.
// R10 - Counters are held in reset so release begins at state one phase one.
`timescale 1ns/1ps
module ccrpu_core_clock_reset_power_unit (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        rstPin,
   input  wire logic        idleReq,
   input  wire logic        pdwnReq,
   input  wire logic        intWake,
   input  wire logic        wdtEnableReq,
   input  wire logic        wdtClear,
   output logic             oscRun,
   output logic             cpuClkEn,
   output logic             periphClkEn,
   output logic             chipRst,
   output logic [2:0]       stateNum,
   output logic             phaseNum,
   output logic             stateStart,
   output logic             state5_phase2_strobe,
   output logic             wdtRunning,
   output logic [23:0]      fetchAddr,
   output logic             fetchAddrLoad,
   output logic             idleMode,
   output logic             pdwnMode
);
   ccrpu_pkg::ccrpu_mode_e mode;
   ccrpu_pkg::ccrpu_mode_e next_mode;
   logic [13:0]             wdtCount;
   logic                    wdtTimeout;
   logic [1:0]              rstHold;
   logic                    chipRstPrev;
   logic                    tick;

   // ==========================================
   // Reset generation
   assign wdtTimeout = wdtRunning && (wdtCount == ccrpu_pkg::WDT_MAX);
   // Hold stretches a one-cycle watchdog timeout into a clean reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rstHold <= ccrpu_pkg::RST_HOLD_CYCLES;
      end else if (rstPin || wdtTimeout) begin
         rstHold <= ccrpu_pkg::RST_HOLD_CYCLES; // R7
      end else if (rstHold != 2'h0) begin
         rstHold <= rstHold - 2'h1;
      end
   end
   assign chipRst = (rstHold != 2'h0);

   // ==========================================
   // Power mode control
   always_comb begin
      next_mode = mode;
      case (mode)
         ccrpu_pkg::CCRPU_RUN: begin
            if (pdwnReq) begin
               next_mode = ccrpu_pkg::CCRPU_PDWN;
            end else if (idleReq) begin
               next_mode = ccrpu_pkg::CCRPU_IDLE;
            end
         end
         ccrpu_pkg::CCRPU_IDLE,
         ccrpu_pkg::CCRPU_PDWN: begin
            if (intWake) begin
               next_mode = ccrpu_pkg::CCRPU_RUN; // R6
            end
         end
         default: begin
            next_mode = ccrpu_pkg::CCRPU_RUN;
         end
      endcase
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode <= ccrpu_pkg::CCRPU_RUN;
      end else if (chipRst) begin
         mode <= ccrpu_pkg::CCRPU_RUN; // R6
      end else begin
         mode <= next_mode;
      end
   end
   assign idleMode    = (mode == ccrpu_pkg::CCRPU_IDLE);
   assign pdwnMode    = (mode == ccrpu_pkg::CCRPU_PDWN);
   // Oscillator halt is modelled as a gate on every timing tick
   assign oscRun      = !pdwnMode; // R5
   assign tick        = oscRun && !chipRst;
   assign periphClkEn = tick; // R4
   assign cpuClkEn    = tick && !idleMode; // R4

   // ==========================================
   // State and phase counters
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stateNum <= ccrpu_pkg::STATE_FIRST;
         phaseNum <= ccrpu_pkg::PHASE_ONE;
      end else if (chipRst) begin
         stateNum <= ccrpu_pkg::STATE_FIRST; // R10
         phaseNum <= ccrpu_pkg::PHASE_ONE; // R10
      end else if (tick) begin
         phaseNum <= ~phaseNum; // R1
         if (phaseNum == ccrpu_pkg::PHASE_TWO) begin
            if (stateNum == ccrpu_pkg::STATE_LAST) begin
               stateNum <= ccrpu_pkg::STATE_FIRST; // R2
            end else begin
               stateNum <= stateNum + 3'h1; // R2
            end
         end
      end
   end
   assign stateStart = tick && (phaseNum == ccrpu_pkg::PHASE_ONE);
   assign state5_phase2_strobe = tick && (stateNum == ccrpu_pkg::STROBE_STATE)
                                 && (phaseNum == ccrpu_pkg::PHASE_TWO); // R3

   // ==========================================
   // Watchdog
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wdtRunning <= 1'b0;
         wdtCount   <= ccrpu_pkg::WDT_ZERO;
      end else if (chipRst) begin
         wdtRunning <= 1'b0; // R8
         wdtCount   <= ccrpu_pkg::WDT_ZERO; // R8
      end else begin
         // Software strobes need a running oscillator, so powerdown keeps the watchdog frozen
         if (wdtEnableReq && oscRun) begin
            wdtRunning <= 1'b1; // R5
         end
         if (wdtClear && oscRun) begin
            wdtCount <= ccrpu_pkg::WDT_ZERO;
         end else if (wdtRunning && tick) begin
            wdtCount <= wdtCount + 14'h0001;
         end
      end
   end

   // ==========================================
   // First fetch address
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         chipRstPrev   <= 1'b1;
         fetchAddr     <= ccrpu_pkg::START_ADDR;
         fetchAddrLoad <= 1'b0;
      end else begin
         chipRstPrev   <= chipRst;
         fetchAddrLoad <= chipRstPrev && !chipRst; // R9
         fetchAddr     <= ccrpu_pkg::START_ADDR; // R9
      end
   end

   // ==========================================
   // Checks
   sequence s_state5_p1;
      tick && stateNum == ccrpu_pkg::STROBE_STATE && phaseNum == ccrpu_pkg::PHASE_ONE;
   endsequence
   property p_strobe;
      @(posedge clk) disable iff (sys_rst) s_state5_p1 ##1 tick |-> state5_phase2_strobe;
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe missing at state 5 phase 2"); // R3
   property p_phase;
      @(posedge clk) disable iff (sys_rst) tick && !chipRst |=> phaseNum != $past(phaseNum);
   endproperty
   a_phase: assert property (p_phase) else $error("phase did not alternate"); // R1
   property p_wrap;
      @(posedge clk) disable iff (sys_rst)
         tick && stateNum == 3'h6 && phaseNum == 1'b1 && !$rose(chipRst) ##1 !chipRst |-> stateNum == 3'h1;
   endproperty
   a_wrap: assert property (p_wrap) else $error("peripheral cycle did not wrap"); // R2
   property p_idle;
      @(posedge clk) disable iff (sys_rst) idleMode |-> !cpuClkEn && (periphClkEn == !chipRst);
   endproperty
   a_idle: assert property (p_idle) else $error("idle clock gating wrong"); // R4
   property p_pdwn;
      @(posedge clk) disable iff (sys_rst) pdwnMode && !intWake && !chipRst |=> $stable(stateNum) && $stable(wdtCount);
   endproperty
   a_pdwn: assert property (p_pdwn) else $error("logic moved in powerdown"); // R5
   property p_wake;
      @(posedge clk) disable iff (sys_rst) (idleMode || pdwnMode) && intWake |=> !idleMode && !pdwnMode;
   endproperty
   a_wake: assert property (p_wake) else $error("wake not honoured"); // R6
   property p_rst;
      @(posedge clk) disable iff (sys_rst) rstPin || wdtTimeout |=> chipRst [*3];
   endproperty
   a_rst: assert property (p_rst) else $error("chip reset not held"); // R7
   property p_wdt;
      @(posedge clk) disable iff (sys_rst) chipRst |=> !wdtRunning;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog left running after reset"); // R8
   property p_fetch;
      @(posedge clk) disable iff (sys_rst) $fell(chipRst) |=> fetchAddrLoad && fetchAddr == ccrpu_pkg::START_ADDR;
   endproperty
   a_fetch: assert property (p_fetch) else $error("first fetch address wrong"); // R9
   property p_release;
      @(posedge clk) disable iff (sys_rst)
         $fell(chipRst) |-> stateNum == ccrpu_pkg::STATE_FIRST && phaseNum == ccrpu_pkg::PHASE_ONE;
   endproperty
   a_release: assert property (p_release) else $error("counters not at state 1 phase 1"); // R10
endmodule : ccrpu_core_clock_reset_power_unit

// ---- verification/ccrpu_periph_model.sv ----
// Peripheral and CPU side model: counter-array timer and first fetch capture
`timescale 1ns/1ps
module ccrpu_periph_model (
   input  wire logic        clk,
   input  wire logic        strobe,
   input  wire logic        load,
   input  wire logic [23:0] addr,
   output logic      [15:0] pcaCount,
   output logic      [23:0] firstFetch
);
   // ==========================================
   // Timer advances once per peripheral cycle
   initial pcaCount = 16'h0000;
   // Plain always: the initial value and the counter share one variable
   always @(posedge clk) begin
      if (strobe) pcaCount <= pcaCount + 16'h0001;
   end
   // Fetch unit takes its start address on the load pulse
   always_ff @(posedge clk) begin
      if (load) firstFetch <= addr;
   end
endmodule : ccrpu_periph_model

// ---- verification/ccrpu_core_clock_reset_power_unit_tb.sv ----
// Self-checking bench for the clock, reset and power unit
`timescale 1ns/1ps
module ccrpu_core_clock_reset_power_unit_tb;
   logic        clk = 1'b0, sys_rst = 1'b1, rstPin = 1'b0, idleReq = 1'b0, pdwnReq = 1'b0;
   logic        intWake = 1'b0, wdtEnableReq = 1'b0, wdtClear = 1'b0;
   logic        oscRun, cpuClkEn, periphClkEn, chipRst, phaseNum, stateStart, state5_phase2_strobe;
   logic        wdtRunning, fetchAddrLoad, idleMode, pdwnMode;
   logic [2:0]  stateNum;
   logic [4:0]  snap;
   logic [15:0] pcaCount, pcaMark;
   logic [23:0] fetchAddr, firstFetch;
   logic [23:0] expQ[$];
   int          nFail = 0, totalChecks = 0, seed = 88364;
   always #2 clk = ~clk;
   ccrpu_core_clock_reset_power_unit u_ccrpu_core_clock_reset_power_unit (.clk(clk), .sys_rst(sys_rst),
      .rstPin(rstPin), .idleReq(idleReq), .pdwnReq(pdwnReq), .intWake(intWake), .wdtEnableReq(wdtEnableReq),
      .wdtClear(wdtClear), .oscRun(oscRun), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .chipRst(chipRst),
      .stateNum(stateNum), .phaseNum(phaseNum), .stateStart(stateStart), .wdtRunning(wdtRunning),
      .state5_phase2_strobe(state5_phase2_strobe), .fetchAddr(fetchAddr), .fetchAddrLoad(fetchAddrLoad),
      .idleMode(idleMode), .pdwnMode(pdwnMode));
   ccrpu_periph_model u_ccrpu_periph_model (.clk(clk), .strobe(state5_phase2_strobe), .load(fetchAddrLoad),
      .addr(fetchAddr), .pcaCount(pcaCount), .firstFetch(firstFetch));
   // ==========================================
   // Shared tasks
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      totalChecks++;
      if (exp !== got) begin
         nFail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   // Bounded wait; the full watchdog count needs the long limit
   task automatic wait_rst(input logic v);
      int n = 0;
      while (chipRst !== v && n < 20000) begin
         cyc(1);
         n++;
      end
      chk("chipRst", 24'(v), 24'(chipRst));
      if (!v) expQ.push_back(ccrpu_pkg::START_ADDR);
   endtask : wait_rst
   // ==========================================
   // Monitor: each load pulse is matched to the oldest note
   always @(negedge clk) begin
      if (fetchAddrLoad === 1'b1) begin
         if (expQ.size() == 0) chk("spare load", 24'h0, 24'h1);
         else chk("fetchAddr", expQ.pop_front(), fetchAddr);
      end
   end
   initial begin
      #200000;
      nFail++;
      report_and_stop();
   end
   // ==========================================
   // Main sequence
   initial begin
      cyc(5);
      sys_rst = 1'b0;
      chk("stretch", 24'h1, 24'(chipRst));
      wait_rst(1'b0);
      pcaMark = pcaCount;
      for (int j = 0; j < 24; j++) begin
         chk("slot", 24'({3'(1 + (j / 2) % 6), 1'(j % 2), 1'(j % 12 == 9), 1'(j % 2 == 0)}),
             24'({stateNum, phaseNum, state5_phase2_strobe, stateStart}));
         cyc(1);
      end
      chk("pca", 24'h2, 24'(pcaCount - pcaMark));
      idleReq = 1'b1;
      cyc(1);
      idleReq = 1'b0;
      chk("idle", 24'h5, 24'({idleMode, cpuClkEn, periphClkEn}));
      snap = {stateNum, phaseNum, state5_phase2_strobe};
      cyc(2 + ($unsigned($random(seed)) % 6));
      chk("periph runs", 24'h1, 24'(snap[4:1] != {stateNum, phaseNum}));
      intWake = 1'b1;
      cyc(1);
      intWake = 1'b0;
      chk("idle wake", 24'h3, 24'({idleMode, cpuClkEn, periphClkEn}));
      pdwnReq = 1'b1;
      idleReq = 1'b1;
      cyc(1);
      pdwnReq = 1'b0;
      idleReq = 1'b0;
      chk("pdwn", 24'h4, 24'({pdwnMode, idleMode, oscRun}));
      snap = {stateNum, phaseNum, state5_phase2_strobe};
      // Idle requests outside run mode must be refused
      idleReq = 1'($random(seed));
      cyc(6);
      idleReq = 1'b0;
      chk("frozen", 24'(snap), 24'({stateNum, phaseNum, state5_phase2_strobe}));
      chk("pdwn held", 24'h1, 24'(pdwnMode));
      intWake = 1'b1;
      cyc(1);
      intWake = 1'b0;
      chk("pdwn wake", 24'h1, 24'({pdwnMode, oscRun}));
      // Pin reset while idle with the watchdog armed
      wdtEnableReq = 1'b1;
      idleReq = 1'b1;
      cyc(1);
      wdtEnableReq = 1'b0;
      idleReq = 1'b0;
      wdtClear = 1'b1;
      cyc(1);
      wdtClear = 1'b0;
      chk("wdt on", 24'h1, 24'(wdtRunning));
      rstPin = 1'b1;
      cyc(1);
      rstPin = 1'b0;
      wait_rst(1'b1);
      wait_rst(1'b0);
      chk("after pin", 24'h0, 24'({wdtRunning, idleMode}));
      // Watchdog left to run out
      wdtEnableReq = 1'b1;
      cyc(1);
      wdtEnableReq = 1'b0;
      wait_rst(1'b1);
      wait_rst(1'b0);
      chk("wdt off", 24'h0, 24'(wdtRunning));
      cyc(2);
      chk("captured", ccrpu_pkg::START_ADDR, firstFetch);
      chk("queue", 24'h0, 24'(expQ.size()));
      report_and_stop();
   end
endmodule : ccrpu_core_clock_reset_power_unit_tb
